/* File: verilog/hbfl_pkg.sv */
// Shared constants, types and register map of the half-bridge driver fault logic
package hbfl_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Command glitch filter
  localparam int unsigned REJECT_NS = 625;
  localparam int unsigned ACCEPT_NS = 750;
  localparam int unsigned REJECT_CYC = (REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCEPT_CYC = ACCEPT_NS / CLK_PERIOD_NS;
  localparam int unsigned FILT_CYC = (REJECT_CYC + ACCEPT_CYC) / 2;
  // Propagation, dead time and fault-clear hold
  localparam int unsigned PROP_NS = 1400;
  localparam int unsigned PROP_CYC = PROP_NS / CLK_PERIOD_NS;
  localparam int unsigned DEAD_NS = 3300;
  localparam int unsigned DEAD_CYC = DEAD_NS / CLK_PERIOD_NS;
  localparam int unsigned CLEAR_NS = 12200;
  localparam int unsigned CLEAR_CYC = (CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // DC-link low-pass: tau = step * 2^shift
  localparam int unsigned LPF_TAU_NS = 500000;
  localparam int unsigned LPF_SHIFT = 4;
  localparam int unsigned LPF_STEP_CYC = (LPF_TAU_NS / CLK_PERIOD_NS) >> LPF_SHIFT;
  // Sample codes: 1 A, 1 V or 1 degC per LSB
  localparam int unsigned CODE_W = 12;
  localparam int unsigned RATED_MON_A = 2000;
  localparam int unsigned RATED_IC_A = 1500;
  localparam logic [11:0] OC_LEVEL_RST = 12'(RATED_MON_A * 125 / 100);
  localparam logic [11:0] GF_LEVEL_RST = 12'(RATED_IC_A * 30 / 100);
  localparam logic [11:0] OT_POINT_RST = 12'h073;
  localparam logic [11:0] DC_LEVEL_1200 = 12'h3A2;
  localparam logic [11:0] DC_LEVEL_1700 = 12'h4B6;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_OC_LEVEL = 8'h08;
  localparam logic [7:0] ADDR_GF_LEVEL = 8'h0C;
  localparam logic [7:0] ADDR_OT_POINT = 8'h10;
  localparam logic [7:0] ADDR_DC_FILT = 8'h14;
  // Control fields
  localparam int unsigned CTRL_DC_EN_BIT = 0;
  localparam int unsigned CTRL_CLASS_BIT = 1;
  localparam int unsigned CTRL_GF_EN_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;

  typedef struct packed {
    logic dc;
    logic uv;
    logic ot;
    logic gf;
    logic oc;
  } hbfl_trip_t;

  typedef enum logic [2:0] {
    FS_RUN = 3'b001,
    FS_TRIP = 3'b010,
    FS_HOLD = 3'b100
  } hbfl_fstate_t;
endpackage

/* File: verilog/hbfl_glitch.sv */
// Command glitch filter: output follows input only after it has been stable N cycles
`timescale 1ns/1ns
module hbfl_glitch import hbfl_pkg::*; #(
  parameter int unsigned N = FILT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic din,
  output logic dout
);
  localparam int unsigned CW = $clog2(N + 1);
  localparam logic [CW-1:0] LAST = CW'(N - 1);
  logic [CW-1:0] cnt_q;

  if (N < 2) begin : g_chk
    $error("hbfl_glitch: N must be at least 2");
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      dout <= 1'b0;
    end else if (din == dout) begin
      cnt_q <= '0;
    end else if (cnt_q == LAST) begin
      cnt_q <= '0;
      dout <= din;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Helper: cycles the input has held its present level
  logic [CW-1:0] run_q;
  logic din_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= '0;
      din_q <= 1'b0;
    end else begin
      din_q <= din;
      run_q <= (din != din_q) ? '0 : ((run_q == LAST) ? run_q : run_q + 1'b1);
    end
  end

  glitch_reject_a: assert property (@(posedge clk) disable iff (!rst_n)
    (dout != $past(dout)) |-> ($past(run_q) == CW'(N - 2) && $past(din) == dout))
    else $error("filter output changed before input was stable");
endmodule

/* File: verilog/hbfl_lpf.sv */
// First-order low-pass on a sample code, updated once per step period
`timescale 1ns/1ns
module hbfl_lpf import hbfl_pkg::*; #(
  parameter int unsigned W = CODE_W,
  parameter int unsigned SHIFT = LPF_SHIFT,
  parameter int unsigned STEP = LPF_STEP_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] x,
  output logic [W-1:0] y
);
  localparam int unsigned SW = $clog2(STEP + 1);
  localparam int unsigned AW = W + SHIFT;
  logic [SW-1:0] tick_q;
  logic [AW-1:0] acc_q;

  if (STEP < 1 || SHIFT < 1) begin : g_chk
    $error("hbfl_lpf: STEP and SHIFT must be at least 1");
  end

  assign y = acc_q[AW-1:SHIFT];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= '0;
    end else begin
      tick_q <= (tick_q == SW'(STEP - 1)) ? '0 : tick_q + 1'b1;
    end
  end

  // Accumulator moves 1/2^SHIFT of the error per step, giving tau = STEP * 2^SHIFT
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else if (tick_q == SW'(STEP - 1)) begin
      acc_q <= acc_q + AW'(x) - AW'(y);
    end
  end
endmodule

/* File: verilog/hbfl_top.sv */
// Half-bridge driver control: glitch filter, delay, dead time and fault memory
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/1ns
module hbfl_top import hbfl_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Command pins from the controller
  input wire logic cmd_top_pin,
  input wire logic cmd_bot_pin,
  // Undervoltage comparator pin, high while the driver supply is too low
  input wire logic supply_low_pin,
  // Sample codes from the converters, same clock
  input wire logic [CODE_W-1:0] current_code,
  input wire logic [CODE_W-1:0] ground_code,
  input wire logic [CODE_W-1:0] temp_code,
  input wire logic [CODE_W-1:0] dc_link_code,
  // Switch drive and fault outputs
  output logic gate_top,
  output logic gate_bot,
  output logic fault_out,
  output logic overtemp_flag_output
);
  localparam int EXTRA_CYC = int'(PROP_CYC) - int'(FILT_CYC) - 2;
  localparam int DEAD_D = int'(DEAD_CYC);
  localparam int unsigned DW = $clog2(DEAD_CYC + 1);
  localparam int unsigned HW = $clog2(CLEAR_CYC + 1);

  if (EXTRA_CYC < 2 || DEAD_CYC < 2 || CLEAR_CYC < 2) begin : g_chk
    $error("hbfl_top: timing constants too small for the pipeline");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Byte-lane merge of a 12-bit field
  function automatic logic [11:0] lane_merge(input logic [11:0] old, input logic [31:0] dat,
                                             input logic [3:0] sel);
    logic [11:0] r;
    r = old;
    if (sel[0]) r[7:0] = dat[7:0];
    if (sel[1]) r[11:8] = dat[11:8];
    return r;
  endfunction

  // ---------------- Pin synchronisers ----------------
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {supply_low_pin, cmd_bot_pin, cmd_top_pin};
      pin_s2_q <= pin_s1_q;
    end
  end

  // ---------------- Registers ----------------
  logic [2:0] ctrl_q;
  logic [11:0] oc_level_q;
  logic [11:0] gf_level_q;
  logic [11:0] ot_point_q;
  logic [CODE_W-1:0] dc_filt;
  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      oc_level_q <= OC_LEVEL_RST;
      gf_level_q <= GF_LEVEL_RST;
      ot_point_q <= OT_POINT_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        ADDR_CTRL: begin
          if (wb_sel_i[0]) ctrl_q <= wb_dat_i[2:0];
        end
        ADDR_OC_LEVEL: oc_level_q <= lane_merge(oc_level_q, wb_dat_i, wb_sel_i);
        ADDR_GF_LEVEL: gf_level_q <= lane_merge(gf_level_q, wb_dat_i, wb_sel_i);
        ADDR_OT_POINT: ot_point_q <= lane_merge(ot_point_q, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // ---------------- Trip sources ----------------
  hbfl_trip_t trip_q;
  logic [11:0] dc_level;
  logic trip_any;
  assign dc_level = ctrl_q[CTRL_CLASS_BIT] ? DC_LEVEL_1700 : DC_LEVEL_1200;
  assign trip_any = |trip_q;

  hbfl_lpf u_dc_lpf (
    .clk(clk),
    .rst_n(rst_n),
    .x(dc_link_code),
    .y(dc_filt)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_q <= '0;
    end else begin
      trip_q.oc <= current_code > oc_level_q;
      trip_q.gf <= ctrl_q[CTRL_GF_EN_BIT] && (ground_code > gf_level_q);
      trip_q.ot <= temp_code >= ot_point_q;
      trip_q.uv <= pin_s2_q[2];
      trip_q.dc <= ctrl_q[CTRL_DC_EN_BIT] && (dc_filt > dc_level);
    end
  end

  // ---------------- Command filter and delay ----------------
  logic [1:0] filt_cmd;
  logic [1:0] dly_cmd;
  logic [1:0] gate;
  logic fault;

  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [EXTRA_CYC-1:0] sh_q;
    logic [DW-1:0] wait_q;
    logic g_q;
    logic allow;

    hbfl_glitch u_glitch (
      .clk(clk),
      .rst_n(rst_n),
      .din(pin_s2_q[i]),
      .dout(filt_cmd[i])
    );

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sh_q <= '0;
      end else begin
        sh_q <= {sh_q[EXTRA_CYC-2:0], filt_cmd[i]};
      end
    end
    assign dly_cmd[i] = sh_q[EXTRA_CYC-1];

    // Both commands high is refused; waiting restarts whenever the other side conducts
    assign allow = dly_cmd[i] && !dly_cmd[1-i] && !gate[1-i] && !fault;

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        wait_q <= '0;
      end else if (!allow) begin
        wait_q <= '0;
      end else if (wait_q != DW'(DEAD_CYC)) begin
        wait_q <= wait_q + 1'b1;
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        g_q <= 1'b0;
      end else begin
        // A trip seen at this edge drops the gate together with the fault state
        g_q <= allow && !trip_any && (g_q || wait_q == DW'(DEAD_CYC));
      end
    end
    assign gate[i] = g_q;
  end

  assign gate_top = gate[0];
  assign gate_bot = gate[1];

  // ---------------- Fault memory ----------------
  hbfl_fstate_t fstate_q;
  logic [HW-1:0] hold_q;
  logic ot_flag_q;
  hbfl_trip_t cause_q;
  logic cmds_low;
  logic clear_done;
  assign cmds_low = !filt_cmd[0] && !filt_cmd[1];
  assign clear_done = (hold_q == HW'(CLEAR_CYC - 1));
  assign fault = (fstate_q != FS_RUN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fstate_q <= FS_RUN;
    end else begin
      case (fstate_q)
        FS_RUN: if (trip_any) fstate_q <= FS_TRIP;
        FS_TRIP: if (!trip_any && cmds_low) fstate_q <= FS_HOLD;
        FS_HOLD: begin
          if (trip_any || !cmds_low) fstate_q <= FS_TRIP;
          else if (clear_done) fstate_q <= FS_RUN;
        end
        default: fstate_q <= FS_TRIP;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q <= '0;
    end else if (fstate_q == FS_HOLD && !clear_done) begin
      hold_q <= hold_q + 1'b1;
    end else begin
      hold_q <= '0;
    end
  end

  // Flags clear when the hold count completes in the hold phase; a new trip in that cycle wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ot_flag_q <= 1'b0;
      cause_q <= '0;
    end else begin
      if (trip_q.ot) ot_flag_q <= 1'b1;
      else if (fstate_q == FS_HOLD && clear_done) ot_flag_q <= 1'b0;
      if (fstate_q == FS_HOLD && clear_done) cause_q <= trip_q;
      else cause_q <= cause_q | trip_q;
    end
  end

  assign fault_out = fault;
  assign overtemp_flag_output = ot_flag_q;

  // ---------------- Wishbone read and acknowledge ----------------
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      ADDR_CTRL: rd_data = {29'h0, ctrl_q};
      ADDR_STATUS: rd_data = {18'h0, cause_q, trip_q, gate, ot_flag_q, fault};
      ADDR_OC_LEVEL: rd_data = {20'h0, oc_level_q};
      ADDR_GF_LEVEL: rd_data = {20'h0, gf_level_q};
      ADDR_OT_POINT: rd_data = {20'h0, ot_point_q};
      ADDR_DC_FILT: rd_data = {20'h0, dc_filt};
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) wb_dat_o <= rd_data;
    end
  end

  // ---------------- Checks ----------------
  logic [DW-1:0] bot_off_q;
  logic [DW-1:0] top_off_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bot_off_q <= '0;
      top_off_q <= '0;
    end else begin
      bot_off_q <= gate_bot ? '0 : ((bot_off_q == DW'(DEAD_CYC)) ? bot_off_q : bot_off_q + 1'b1);
      top_off_q <= gate_top ? '0 : ((top_off_q == DW'(DEAD_CYC)) ? top_off_q : top_off_q + 1'b1);
    end
  end

  fault_forces_off_a: assert property (fault |-> !gate_top && !gate_bot)
    else $error("switch driven while fault memory set");
  no_overlap_a: assert property (!(gate_top && gate_bot))
    else $error("both switches on together");
  dead_time_a: assert property ($rose(gate_top) |-> $past(bot_off_q) == DW'(DEAD_CYC))
    else $error("top switch on before dead time elapsed");
  dead_bot_a: assert property ($rose(gate_bot) |-> $past(top_off_q) == DW'(DEAD_CYC))
    else $error("bottom switch on before dead time elapsed");
  turn_on_delay_a: assert property ($rose(gate_top) |-> $past(dly_cmd[0], DEAD_D))
    else $error("turn-on earlier than dead time after delayed command");
  turn_off_delay_a: assert property ($fell(filt_cmd[0]) |-> ##EXTRA_CYC !dly_cmd[0])
    else $error("command delay line length wrong");
  trip_sets_fault_a: assert property (trip_any |=> fault_out)
    else $error("trip source did not set fault memory");
  overtemp_flag_a: assert property (trip_q.ot |=> overtemp_flag_output && fault_out)
    else $error("overtemperature did not raise both outputs");
  clear_hold_a: assert property ($fell(fault) |->
    $past(cmds_low) && !$past(trip_any) && $past(hold_q) == HW'(CLEAR_CYC - 1))
    else $error("fault memory cleared without full hold");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");

  // Trip reactions for overcurrent, ground fault, undervoltage and dc-link, the turn-on command delay, and the bus answer
  oc_trip_a: assert property (
    current_code > oc_level_q |-> ##2 fault_out)
    else $error("overcurrent did not set fault memory");
  gf_trip_a: assert property (
    ctrl_q[CTRL_GF_EN_BIT] && ground_code > gf_level_q |-> ##2 fault_out)
    else $error("ground fault did not set fault memory");
  gf_off_a: assert property (
    !ctrl_q[CTRL_GF_EN_BIT] |=> !trip_q.gf)
    else $error("ground fault tripped while disabled");
  uv_trip_a: assert property (
    pin_s2_q[2] |-> ##2 fault_out)
    else $error("undervoltage did not set fault memory");
  dc_off_a: assert property (
    !ctrl_q[CTRL_DC_EN_BIT] |=> !trip_q.dc)
    else $error("dc-link trip while monitoring disabled");
  dc_low_class_a: assert property (
    ctrl_q[CTRL_DC_EN_BIT] && !ctrl_q[CTRL_CLASS_BIT] && dc_filt > DC_LEVEL_1200 |-> ##2 fault_out)
    else $error("dc-link overvoltage missed in lower class");
  dc_high_class_a: assert property (
    ctrl_q[CTRL_DC_EN_BIT] && ctrl_q[CTRL_CLASS_BIT] && dc_filt <= DC_LEVEL_1700 |=> !trip_q.dc)
    else $error("dc-link trip below upper class level");
  rise_delay_a: assert property (
    $rose(filt_cmd[0]) |-> ##EXTRA_CYC dly_cmd[0])
    else $error("turn-on command delay line length wrong");
  ack_follow_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
endmodule

/* File: bench/hbfl_pwm_ctrl.sv */
// PWM controller model driving the two command pins
`timescale 1ns/1ns
module hbfl_pwm_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wanted switch states and own gap in cycles
  input wire logic want_top,
  input wire logic want_bot,
  input wire logic [15:0] gap,
  // Command pins
  output logic cmd_top_pin,
  output logic cmd_bot_pin
);
  logic [15:0] idle_q;

  // Cycles with both pins low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_q <= 16'h0000;
    end else if (cmd_top_pin || cmd_bot_pin) begin
      idle_q <= 16'h0000;
    end else if (idle_q != 16'hFFFF) begin
      idle_q <= idle_q + 16'h0001;
    end
  end

  // Pins stay low through reset; a pin rises only while the other is low, so both rise if both are wanted from idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_top_pin <= 1'b0;
      cmd_bot_pin <= 1'b0;
    end else begin
      cmd_top_pin <= want_top && !cmd_bot_pin && (cmd_top_pin || idle_q >= gap);
      cmd_bot_pin <= want_bot && !cmd_top_pin && (cmd_bot_pin || idle_q >= gap);
    end
  end
endmodule

/* File: bench/test_hbfl_top.sv */
// Self-checking bench for the half-bridge driver fault logic
`timescale 1ns/1ns
module test_hbfl_top import hbfl_pkg::*; ;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic want_top = 1'b0;
  logic want_bot = 1'b0;
  logic sup_low = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] dat_o;
  logic ack, ct, cb, g_top, g_bot, flt, otf;
  logic [11:0] cur = 12'h000;
  logic [11:0] gnd = 12'h000;
  logic [11:0] tmp = 12'h014;
  logic [11:0] dcl = 12'h000;
  logic [15:0] gap = 16'h0000;
  int num_errors = 0;
  int n_compared = 0;
  int cyc_cnt = 0;
  wire [5:0] obs = {flt, otf, g_bot, g_top, cb, ct};

  always #5 clk = ~clk;

  hbfl_pwm_ctrl ctrl_u (.clk(clk), .rst_n(rst_n), .want_top(want_top),
    .want_bot(want_bot), .gap(gap), .cmd_top_pin(ct), .cmd_bot_pin(cb));

  hbfl_top dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .cmd_top_pin(ct), .cmd_bot_pin(cb),
    .supply_low_pin(sup_low), .current_code(cur), .ground_code(gnd),
    .temp_code(tmp), .dc_link_code(dcl), .gate_top(g_top), .gate_bot(g_bot),
    .fault_out(flt), .overtemp_flag_output(otf));

  task wrap_up();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 90000) begin
      num_errors++;
      wrap_up();
    end
  end

  // Both gates on at once is never allowed
  always @(posedge clk) begin
    if (g_top === 1'b1 && g_bot === 1'b1) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, 2'h3, 2'h0);
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  function logic near(int n, int e);
    return n >= e - 2 && n <= e + 4;
  endfunction

  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk(n < 20, 1);
    if (n >= 20) wrap_up();
    @(posedge clk);
  endtask

  // Wait up to lim cycles for one observed bit to reach v
  task wt(input int i, input logic v, input int lim, output int n);
    n = 0;
    while (obs[i] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask

  // Drive one trip source active, or inactive (just short of tripping for current and temperature)
  task src(input int s, input logic on);
    case (s)
      0: cur <= on ? 12'(RATED_MON_A * 125 / 100 + 1 + $urandom % 99) : 12'h9C4;
      1: gnd <= on ? 12'(RATED_IC_A * 30 / 100 + 1 + $urandom % 99) : 12'h000;
      2: tmp <= on ? OT_POINT_RST : OT_POINT_RST - 12'h001;
      default: sup_low <= on;
    endcase
  endtask

  initial begin
    int n;
    int k;
    void'($urandom(32'hA340));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk(obs[5:2], 32'h0);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'(CTRL_RST));
    wb(1'b0, ADDR_OC_LEVEL, 32'h0);
    chk(rd, RATED_MON_A * 125 / 100);
    wb(1'b0, ADDR_GF_LEVEL, 32'h0);
    chk(rd, RATED_IC_A * 30 / 100);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    want_top <= 1'b1;
    wt(0, 1'b1, 10, k);
    wt(2, 1'b1, 1000, n);
    chk(near(n, PROP_CYC + DEAD_CYC), 1);
    // Short off pulses vanish, the last, longer one gets through
    for (k = 0; k < 5; k++) begin
      want_top <= 1'b0;
      repeat (k < 4 ? 20 + $urandom % 40 : 76 + $urandom % 30) @(posedge clk);
      want_top <= 1'b1;
      wt(2, 1'b0, 400, n);
      chk(n < 400, k == 4);
    end
    wt(2, 1'b1, 1000, n);
    want_top <= 1'b0;
    wt(0, 1'b0, 10, k);
    wt(2, 1'b0, 300, n);
    chk(n >= PROP_CYC - 2 && n <= PROP_CYC + 2, 1);
    // Commutation with no gap and with a gap of the controller's own
    for (k = 0; k < 2; k++) begin
      want_top <= 1'b1;
      wt(2, 1'b1, 1000, n);
      gap <= 16'(k * 200);
      want_top <= 1'b0;
      want_bot <= 1'b1;
      wt(1, 1'b1, 400, n);
      wt(3, 1'b1, 1000, n);
      chk(near(n, PROP_CYC + DEAD_CYC), 1);
      want_bot <= 1'b0;
      wt(3, 1'b0, 400, n);
    end
    gnd <= 12'hFFF;
    repeat (10) @(posedge clk);
    chk(flt, 1'b0);
    gnd <= 12'h000;
    wb(1'b1, ADDR_CTRL, 32'h5);
    for (k = 0; k < 4; k++) begin
      want_top <= 1'b1;
      wt(2, 1'b1, 1000, n);
      src(k, 1'b1);
      repeat (5) @(posedge clk);
      chk(obs[5:2], {1'b1, k == 2, 2'b00});
      src(k, 1'b0);
      repeat (1500) @(posedge clk);
      chk(flt, 1'b1);
      want_top <= 1'b0;
      wt(5, 1'b0, 3000, n);
      chk(n >= CLEAR_CYC && n <= CLEAR_CYC + PROP_CYC, 1);
      chk(otf, 1'b0);
    end
    dcl <= 12'hFFF;
    repeat (1000) @(posedge clk);
    dcl <= 12'h000;
    repeat (20) @(posedge clk);
    chk(flt, 1'b0);
    wb(1'b1, ADDR_CTRL, 32'h3);
    dcl <= 12'hFFF;
    k = 0;
    do begin
      repeat (400) @(posedge clk);
      wb(1'b0, ADDR_DC_FILT, 32'h0);
      k++;
    end while (rd <= 32'h3A2 && k < 100);
    repeat (3) @(posedge clk);
    chk(flt, rd > 32'h4B6);
    dcl <= 12'h000;
    wb(1'b1, ADDR_CTRL, 32'h1);
    repeat (5) @(posedge clk);
    chk(flt, 1'b1);
    wb(1'b1, ADDR_CTRL, 32'h0);
    wt(5, 1'b0, 3000, n);
    chk(n < 3000, 1);
    wrap_up();
  end
endmodule
